/* testbench/rdcs_osc_model.sv */
// oscillator and pll stand-in facing the reset sequencer
// assumes clk is the sequencer reference; outputs change on its falling edge
module rdcs_osc_model #(
    parameter int DIV = 2
) (
    // reference
    input wire logic clk,
    // scenario control
    input wire logic fail,
    // oscillator side
    output logic osc_tick,
    output logic clock_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    // quiet lines at time zero so nothing reads as a tick before the first edge
    initial begin
        osc_tick = 1'b0;
        clock_valid = 1'b0;
    end
    // one tick per oscillator period; a dead crystal gives no ticks and no valid clock
    always @(negedge clk) begin
        cnt <= (cnt + 1) % DIV;
        osc_tick <= !fail && cnt == 0;
        clock_valid <= !fail;
    end
endmodule

/* testbench/tb_reset_delay_clock_select.sv */
// self-checking bench for the reset delay and clock select sequencer
// assumes rdcs_osc_model as oscillator; long delays shortened by parameter
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module tb_reset_delay_clock_select;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int POR = 10, SREG = 20, POWER_UP_TIMER = 60, RST = 20, LOCK = 20, MON = 50, DIV = 2;
    logic clk, rst_n, sw_en, reg_en, mon_en, fail, rc_wr, osc_tick, clock_valid, ce, slp;
    logic srs, exe, clkr, mona, trap;
    logic [2:0] cfg, src, cur;
    logic [15:0] rc_wdata, rc, oc;
    logic [31:0] seed = 32'hd0a4;
    rdcs_pkg::rdcs_events_s ev;
    int bad_count = 0;
    int comparisons = 0;
    int tr, tc, tm, te;
    int frz = 0;
    int rcbit [7] = '{0, 1, 7, 4, 6, 14, 15};
    ////////////////////////////////////////////////////////////////////////////
    rdcs_sequencer #(.POR_CYC(POR), .STARTUP_REG_CYC(SREG), .POWER_UP_TIMER_CYC(POWER_UP_TIMER), .RST_CYC(RST),
        .LOCK_CYC(LOCK), .MONITOR_CYC(MON), .TW(22)) dut_u (
        .clk(clk), .rst_n(rst_n), .ce(ce), .events(ev), .clk_switch_en(sw_en),
        .regulator_en(reg_en), .monitor_en(mon_en), .new_osc_config_field(cfg),
        .sleep_entry(slp), .idle_entry(1'b0), .osc_tick(osc_tick), .clock_valid(clock_valid),
        .rc_wr(rc_wr), .rc_wdata(rc_wdata), .oc_wr(1'b0), .oc_wdata(16'h0000),
        .system_reset_signal(srs), .exec_enable(exe), .clk_released(clkr),
        .monitor_active(mona), .osc_fail_trap(trap), .clk_source(src),
        .reset_control_reg(rc), .osc_control_reg(oc));
    rdcs_osc_model #(.DIV(DIV)) osc_u (.clk(clk), .fail(fail), .osc_tick(osc_tick),
        .clock_valid(clock_valid));
    // free-running 20 mhz reference
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    // reference model: delays in cycles from the reset event
    function automatic int exp_rst(input int k, input logic r);
        int st;
        st = r ? SREG : POWER_UP_TIMER;
        return k == 0 ? POR + st + RST : k == 1 ? st + RST : k == 7 ? SREG : RST;
    endfunction
    function automatic int exp_clk(input logic [2:0] s);
        case (s)
            3'h2, 3'h4: return 1024 * DIV;
            3'h3: return 1024 * DIV > LOCK ? 1024 * DIV : LOCK;
            3'h1, 3'h7: return LOCK;
            default: return 0;
        endcase
    endfunction
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // executing while reset held or clock not released is never allowed
    always @(negedge clk) begin
        if (rst_n && exe === 1'b1) `CHK({clkr, srs}, 2'b10)
    end
    ////////////////////////////////////////////////////////////////////////////
    // pulse one event and time each output's release; a release counts only
    // after the output was seen in its held state, so stale levels never match
    task automatic fire(input int k, input int lim);
        logic sr, sc, sm, se;
        sr = 0;
        sc = 0;
        sm = 0;
        se = 0;
        tr = -1;
        tc = -1;
        tm = -1;
        te = -1;
        ev = rdcs_pkg::rdcs_events_s'(8'h80 >> k);
        for (int n = 1; n <= lim; n++) begin
            @(negedge clk);
            ev = '0;
            ce = n < 4 || n >= 4 + frz;
            if (srs === 1'b1) sr = 1;
            else if (sr && tr < 0 && srs === 1'b0) tr = n;
            if (clkr === 1'b0) sc = 1;
            else if (sc && tc < 0 && clkr === 1'b1) tc = n;
            if (mona === 1'b0) sm = 1;
            else if (sm && tm < 0 && mona === 1'b1) tm = n;
            if (exe === 1'b0) se = 1;
            else if (se && te < 0 && exe === 1'b1) te = n;
        end
    endtask
    task automatic por_run();
        int er, ec, ex;
        er = exp_rst(0, reg_en);
        ec = exp_clk(cfg);
        ex = er > ec ? er : ec;
        fire(0, ex + MON + 40);
        `CHK(tr >= er && tr <= er + 5, 1'b1)
        if (ec > 0) `CHK(tc >= ex && tc <= ex + 6, 1'b1)
        if (ec > 0) `CHK(tm >= tc + MON && tm <= tc + MON + 4, 1'b1)
        `CHK(te >= ex && te <= ex + 8, 1'b1)
        `CHK(src, cfg)
        `CHK(rc[1:0], 2'b11)
        `CHK(oc[14:12], cfg)
    endtask
    task automatic swrite(input logic [15:0] d);
        rc_wdata = d;
        rc_wr = 1'b1;
        @(negedge clk);
        rc_wr = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task automatic close_out();
        $display("counts: %0d compared, %0d bad", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // cut a hang well past the longest expected run
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        close_out();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        {sw_en, reg_en, mon_en, fail, rc_wr} = '0;
        {ce, slp} = 2'b10;
        cfg = 3'h0;
        rc_wdata = 16'h0000;
        ev = '0;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        sw_en = 1'b1;
        mon_en = 1'b1;
        // power-on with random source and regulator setting
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(lfsr(lfsr(seed)));
            cfg = seed[2:0];
            reg_en = seed[3];
            por_run();
            $display("test por source %0d regulator %0b done", cfg, reg_en);
        end
        // every short reset kind sets its own flag and waits only the state reset
        for (int k = 2; k < 7; k++) begin
            swrite(16'h0000);
            fire(k, 40);
            `CHK(tr >= RST && tr <= RST + 5, 1'b1)
            `CHK(rc[rcbit[k]], 1'b1)
            `CHK(src, cfg)
        end
        $display("test short resets done");
        // software writes to the flags must not start a reset
        swrite(16'hffff);
        `CHK(rc, 16'hc0df | {7'h00, reg_en, 8'h00})
        `CHK(srs, 1'b0)
        swrite(16'h0000);
        `CHK(rc, {7'h00, reg_en, 8'h00})
        $display("test flag writes done");
        // pin reset keeps current source unless switching is off
        cur = src;
        cfg = cfg + 3'h1;
        fire(2, 40);
        `CHK(src, cur)
        `CHK(oc[14:12], cur)
        sw_en = 1'b0;
        fire(2, 40);
        `CHK(src, cfg)
        sw_en = 1'b1;
        $display("test source selection done");
        // dead oscillator at monitor start falls back to fast rc and traps
        cfg = 3'h6;
        fail = 1'b1;
        fire(0, 300);
        `CHK(trap, 1'b1)
        `CHK(src, 3'h0)
        fail = 1'b0;
        por_run();
        `CHK(trap, 1'b0)
        $display("test monitor fail done");
        // brown-out: no power-on delay, power-on flag kept, new field taken
        fire(1, exp_rst(1, reg_en) + 40);
        `CHK(tr >= exp_rst(1, reg_en) && tr <= exp_rst(1, reg_en) + 5, 1'b1)
        `CHK(rc[1:0], 2'b11)
        `CHK(src, cfg)
        // wake reloads the start-up delay only with the regulator on
        reg_en = 1'b1;
        fire(7, SREG + 30);
        `CHK(tr >= exp_rst(7, 1'b1) && tr <= exp_rst(7, 1'b1) + 5, 1'b1)
        reg_en = 1'b0;
        fire(7, 30);
        `CHK(tr, -1)
        `CHK(srs, 1'b0)
        // a frozen clock enable stretches a pin reset by the frozen cycles
        frz = 10;
        fire(2, 50);
        frz = 0;
        `CHK(tr >= RST + 10 && tr <= RST + 15, 1'b1)
        // sleep entry sets its flag and clears the watchdog flag
        fire(3, 40);
        `CHK(rc[4], 1'b1)
        slp = 1'b1;
        @(negedge clk);
        slp = 1'b0;
        `CHK(rc[4:3], 2'b01)
        $display("test brown-out, wake, freeze and sleep done");
        close_out();
    end
endmodule

/* verilog/rdcs_defines.svh */
// constants for the reset delay and clock select sequencer
// assumes a 20 mhz clk; all times are nominal figures from the block spec
`ifndef RDCS_DEFINES_SVH
`define RDCS_DEFINES_SVH
`define RDCS_CLK_MHZ 20
`define RDCS_T_POR_US 10
`define RDCS_T_STARTUP_REG_US 20
`define RDCS_T_POWER_UP_TIMER_MS 64
`define RDCS_T_RST_US 20
`define RDCS_T_LOCK_US 20
`define RDCS_T_MONITOR_US 500
`define RDCS_OST_PERIODS 1024
`define RDCS_OST_WIDTH 10
// cycle counts derived from the times above
`define RDCS_POR_CYC (`RDCS_T_POR_US * `RDCS_CLK_MHZ)
`define RDCS_STARTUP_REG_CYC (`RDCS_T_STARTUP_REG_US * `RDCS_CLK_MHZ)
`define RDCS_POWER_UP_TIMER_CYC (`RDCS_T_POWER_UP_TIMER_MS * 1000 * `RDCS_CLK_MHZ)
`define RDCS_RST_CYC (`RDCS_T_RST_US * `RDCS_CLK_MHZ)
`define RDCS_LOCK_CYC (`RDCS_T_LOCK_US * `RDCS_CLK_MHZ)
`define RDCS_MONITOR_CYC (`RDCS_T_MONITOR_US * `RDCS_CLK_MHZ)
// oscillator source encodings of the 3-bit clock source field
`define RDCS_SRC_FRC 3'h0
`define RDCS_SRC_FRCPLL 3'h1
`define RDCS_SRC_XT 3'h2
`define RDCS_SRC_XTPLL 3'h3
`define RDCS_SRC_SECONDARY_OSC 3'h4
`define RDCS_SRC_INTERNAL_LOW_POWER_RC_OSC 3'h5
`define RDCS_SRC_EC 3'h6
`define RDCS_SRC_ECPLL 3'h7
// reset control register bit positions
`define RDCS_RC_TRAP 15
`define RDCS_RC_IOPU 14
`define RDCS_RC_REGSLP 8
`define RDCS_RC_EXT 7
`define RDCS_RC_SW 6
`define RDCS_RC_WDT 4
`define RDCS_RC_SLEEP 3
`define RDCS_RC_IDLE 2
`define RDCS_RC_BOR 1
`define RDCS_RC_POR 0
`define RDCS_RC_IMPL_MASK 16'hC1DF
// oscillator control register fields of the current and new source
`define RDCS_OC_CUR_LSB 12
`define RDCS_OC_NEW_LSB 8
`endif

/* verilog/rdcs_delay_timer.sv */
// loadable down counter timing one nominal delay
// assumes load and the clock enable come from the sequencer
`include "rdcs_defines.svh"
module rdcs_delay_timer #(
    parameter int W = 21
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // control
    input wire logic load,
    input wire logic [W-1:0] count,
    // status
    output logic done
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic done;
    } rdcs_tmr_s;
    rdcs_tmr_s q;
    rdcs_tmr_s next_q;
    // counts down; done is a level held once zero is reached
    always_comb begin
        next_q = q;
        if (load) begin
            next_q.cnt = count;
            next_q.done = (count == '0);
        end else if (q.cnt != '0) begin
            next_q.cnt = q.cnt - W'(1);
            next_q.done = (q.cnt == W'(1));
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= next_q;
        end
    end
    assign done = q.done;
endmodule

/* verilog/rdcs_ost_counter.sv */
// oscillator start-up counter, counts oscillator periods given as ticks
// assumes osc_tick is a one-cycle pulse per oscillator period, synchronous to clk
`include "rdcs_defines.svh"
module rdcs_ost_counter #(
    parameter int W = `RDCS_OST_WIDTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // control
    input wire logic start,
    input wire logic osc_tick,
    // status
    output logic done
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic run;
        logic done;
    } rdcs_ost_s;
    rdcs_ost_s q;
    rdcs_ost_s next_q;
    // wraps after 2**W periods, then releases the oscillator
    always_comb begin
        next_q = q;
        if (start) begin
            next_q = '0;
            next_q.run = 1'b1;
        end else if (q.run && osc_tick) begin
            next_q.cnt = q.cnt + W'(1);
            if (q.cnt == {W{1'b1}}) begin
                next_q.run = 1'b0;
                next_q.done = 1'b1;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= next_q;
        end
    end
    assign done = q.done;
endmodule

/* verilog/rdcs_pkg.sv */
// types shared by the reset delay and clock select sequencer
// assumes rdcs_defines.svh is compiled alongside
package rdcs_pkg;
    // reset and wake events, one-cycle pulses
    typedef struct packed {
        logic por;
        logic bor;
        logic pin;
        logic wdt;
        logic sw;
        logic iopu;
        logic trap;
        logic wake;
    } rdcs_events_s;
    typedef enum logic [2:0] {
        RDCS_RUN = 3'b000,
        RDCS_HOLD = 3'b001,
        RDCS_CLKWAIT = 3'b011,
        RDCS_MONWAIT = 3'b010
    } rdcs_state_e;
    typedef struct packed {
        logic [15:0] rc;
        logic [15:0] oc;
        logic [2:0] src;
        rdcs_state_e st;
        logic rst_busy;
        logic clk_ok;
        logic mon_on;
        logic fail_trap;
        logic switched;
    } rdcs_state_s;
endpackage

/* verilog/rdcs_sequencer.sv */
// reset release sequencer: clock source pick, reset delays, clock release,
// clock monitor start, reset cause and oscillator control values
// assumes all inputs synchronous to clk, which is an always-running reference
`include "rdcs_defines.svh"
module rdcs_sequencer #(
    parameter int POR_CYC = `RDCS_POR_CYC,
    parameter int STARTUP_REG_CYC = `RDCS_STARTUP_REG_CYC,
    parameter int POWER_UP_TIMER_CYC = `RDCS_POWER_UP_TIMER_CYC,
    parameter int RST_CYC = `RDCS_RST_CYC,
    parameter int LOCK_CYC = `RDCS_LOCK_CYC,
    parameter int MONITOR_CYC = `RDCS_MONITOR_CYC,
    parameter int TW = 22
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // reset and wake sources
    input wire rdcs_pkg::rdcs_events_s events,
    // configuration
    input wire logic clk_switch_en,
    input wire logic regulator_en,
    input wire logic monitor_en,
    input wire logic [2:0] new_osc_config_field,
    input wire logic sleep_entry,
    input wire logic idle_entry,
    // oscillator side
    input wire logic osc_tick,
    input wire logic clock_valid,
    // software access to the two registers
    input wire logic rc_wr,
    input wire logic [15:0] rc_wdata,
    input wire logic oc_wr,
    input wire logic [15:0] oc_wdata,
    // outputs
    output logic system_reset_signal,
    output logic exec_enable,
    output logic clk_released,
    output logic monitor_active,
    output logic osc_fail_trap,
    output logic [2:0] clk_source,
    output logic [15:0] reset_control_reg,
    output logic [15:0] osc_control_reg
);
    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic is_xtal(input logic [2:0] s);
        return s == `RDCS_SRC_XT || s == `RDCS_SRC_XTPLL || s == `RDCS_SRC_SECONDARY_OSC;
    endfunction
    function automatic logic is_pll(input logic [2:0] s);
        return s == `RDCS_SRC_FRCPLL || s == `RDCS_SRC_XTPLL || s == `RDCS_SRC_ECPLL;
    endfunction
    rdcs_pkg::rdcs_state_s q;
    rdcs_pkg::rdcs_state_s next_q;
    logic any_rst;
    logic power_rst;
    logic rst_done;
    logic lock_done;
    logic mon_done;
    logic ost_done;
    logic load_rst;
    logic load_lock;
    logic load_mon;
    logic [2:0] pick_src;
    logic [TW-1:0] rst_count;
    logic [TW-1:0] lock_count;
    logic [TW-1:0] mon_count;
    logic [15:0] rc_set;
    assign power_rst = events.por | events.bor;
    assign any_rst = power_rst | events.pin | events.wdt | events.sw | events.iopu
                   | events.trap;
    ////////////////////////////////////////////////////////////////////////
    // delay loads chosen by reset type and source
    always_comb begin
        // switching on keeps the current field for soft resets
        if (clk_switch_en && !power_rst) begin
            pick_src = q.oc[`RDCS_OC_CUR_LSB +: 3];
        end else begin
            pick_src = new_osc_config_field;
        end
        // power-on sums three delays and brown-out two; other resets use only internal time
        if (events.por) begin
            rst_count = TW'(POR_CYC + (regulator_en ? STARTUP_REG_CYC : POWER_UP_TIMER_CYC) + RST_CYC);
        end else if (events.bor) begin
            rst_count = TW'((regulator_en ? STARTUP_REG_CYC : POWER_UP_TIMER_CYC) + RST_CYC);
        end else if (any_rst) begin
            rst_count = TW'(RST_CYC);
        end else begin
            rst_count = TW'(STARTUP_REG_CYC); // wake path
        end
        lock_count = TW'(LOCK_CYC);
        mon_count = TW'(MONITOR_CYC);
    end
    assign load_rst = any_rst | (events.wake & regulator_en);
    // clock delays only on power resets, in parallel with the reset delay
    assign load_lock = power_rst;
    // monitor delay loads once, on the first monitor-wait cycle; a load held
    // every cycle would never let it count down
    assign load_mon = q.st == rdcs_pkg::RDCS_MONWAIT && q.rst_busy;
    rdcs_delay_timer #(.W(TW)) u_rst_tmr (
        .clk(clk), .rst_n(rst_n), .ce(ce),
        .load(load_rst), .count(rst_count), .done(rst_done)
    );
    rdcs_delay_timer #(.W(TW)) u_lock_tmr (
        .clk(clk), .rst_n(rst_n), .ce(ce),
        .load(load_lock), .count(lock_count), .done(lock_done)
    );
    rdcs_delay_timer #(.W(TW)) u_mon_tmr (
        .clk(clk), .rst_n(rst_n), .ce(ce),
        .load(load_mon), .count(mon_count), .done(mon_done)
    );
    rdcs_ost_counter #(.W(`RDCS_OST_WIDTH)) u_ost (
        .clk(clk), .rst_n(rst_n), .ce(ce),
        .start(power_rst), .osc_tick(osc_tick), .done(ost_done)
    );
    ////////////////////////////////////////////////////////////////////////
    // reset cause flags set by events
    always_comb begin
        rc_set = '0;
        rc_set[`RDCS_RC_POR] = events.por;
        rc_set[`RDCS_RC_BOR] = power_rst;
        rc_set[`RDCS_RC_EXT] = events.pin;
        rc_set[`RDCS_RC_SW] = events.sw;
        rc_set[`RDCS_RC_WDT] = events.wdt;
        rc_set[`RDCS_RC_SLEEP] = sleep_entry;
        rc_set[`RDCS_RC_IDLE] = idle_entry;
        rc_set[`RDCS_RC_IOPU] = events.iopu;
        rc_set[`RDCS_RC_TRAP] = events.trap;
    end
    ////////////////////////////////////////////////////////////////////////
    // main state
    always_comb begin
        next_q = q;
        // software writes only store, never reset; set wins over write
        if (rc_wr) begin
            next_q.rc = rc_wdata & `RDCS_RC_IMPL_MASK;
        end
        if (oc_wr) begin
            next_q.oc = oc_wdata;
        end
        // clearing events: power-on clears all but its own flags; brown-out also keeps pin and power-on
        if (events.por) begin
            next_q.rc = '0;
        end else if (events.bor) begin
            // brown-out keeps the pin and power-on flags, it clears neither
            next_q.rc = next_q.rc & ((16'h0001 << `RDCS_RC_EXT) | (16'h0001 << `RDCS_RC_POR));
        end
        if (sleep_entry || idle_entry) begin
            next_q.rc[`RDCS_RC_WDT] = 1'b0;
        end
        next_q.rc = next_q.rc | rc_set;
        next_q.rc[`RDCS_RC_REGSLP] = regulator_en;
        case (q.st)
            rdcs_pkg::RDCS_RUN: begin
                if (monitor_en && q.mon_on && !clock_valid && !q.switched) begin
                    next_q.src = `RDCS_SRC_FRC;
                    next_q.oc[`RDCS_OC_CUR_LSB +: 3] = `RDCS_SRC_FRC;
                    next_q.fail_trap = 1'b1;
                    next_q.switched = 1'b1;
                end
            end
            rdcs_pkg::RDCS_HOLD: begin
                if (rst_done && !q.rst_busy) begin
                    next_q.rst_busy = 1'b0;
                    next_q.st = rdcs_pkg::RDCS_CLKWAIT;
                end
                next_q.rst_busy = 1'b0;
            end
            rdcs_pkg::RDCS_CLKWAIT: begin
                // clock release needs start-up count and lock as source asks
                if ((!is_xtal(q.src) || ost_done) && (!is_pll(q.src) || lock_done)) begin
                    next_q.clk_ok = 1'b1;
                    next_q.rst_busy = 1'b1;
                    next_q.st = rdcs_pkg::RDCS_MONWAIT;
                end
            end
            rdcs_pkg::RDCS_MONWAIT: begin
                next_q.rst_busy = 1'b0;
                // monitor starts after its delay only for crystal or pll
                if (!q.rst_busy && (mon_done || !(is_xtal(q.src) || is_pll(q.src)))) begin
                    next_q.mon_on = 1'b1;
                    next_q.st = rdcs_pkg::RDCS_RUN;
                end
            end
            default: begin
                next_q.st = rdcs_pkg::RDCS_HOLD;
            end
        endcase
        // any reset, or a wake with the regulator on, restarts the sequence
        if (load_rst) begin
            next_q.st = rdcs_pkg::RDCS_HOLD;
            next_q.rst_busy = 1'b1;
            next_q.fail_trap = 1'b0;
            next_q.switched = 1'b0;
            next_q.mon_on = 1'b0;
            if (any_rst) begin
                next_q.src = pick_src;
                // oscillator control depends on reset type and config
                next_q.oc = {1'b0, pick_src, 1'b0, new_osc_config_field, 8'h00};
                // soft resets keep a clock already released; one cut short during a
                // power-on wait still waits for start-up count and lock
                next_q.clk_ok = q.clk_ok && !power_rst;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
            q.st <= rdcs_pkg::RDCS_HOLD;
            q.rst_busy <= 1'b1;
        end else if (ce) begin
            q <= next_q;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // registered outputs
    logic st_hold_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_hold_q <= 1'b1;
            exec_enable <= 1'b0;
        end else if (ce) begin
            st_hold_q <= next_q.st == rdcs_pkg::RDCS_HOLD;
            exec_enable <= next_q.st != rdcs_pkg::RDCS_HOLD && next_q.clk_ok;
        end
    end
    assign system_reset_signal = st_hold_q;
    assign clk_released = q.clk_ok;
    assign monitor_active = q.mon_on;
    assign osc_fail_trap = q.fail_trap;
    assign clk_source = q.src;
    assign reset_control_reg = q.rc;
    assign osc_control_reg = q.oc;
    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_fail_start;
        monitor_active && !clock_valid && !osc_fail_trap;
    endsequence
    chk_reset_held_exec: assert property (@(posedge clk) disable iff (!rst_n)
        system_reset_signal |-> !exec_enable) else $error("exec during reset");
    chk_fail_switch_frc: assert property (@(posedge clk) disable iff (!rst_n)
        s_fail_start ##0 (monitor_en && ce && !load_rst && q.st == rdcs_pkg::RDCS_RUN)
        |=> osc_fail_trap && clk_source == `RDCS_SRC_FRC) else $error("no fail switch");
    chk_por_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
        (events.por && ce) |=> reset_control_reg[`RDCS_RC_POR]) else $error("por flag");
    chk_nopll_no_clk: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(clk_released) && is_pll(clk_source) |-> lock_done) else $error("early pll");
    chk_xtal_ost_done: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(clk_released) && is_xtal(clk_source) |-> ost_done) else $error("early ost");
    chk_soft_keep_src: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && events.pin && !power_rst && clk_switch_en)
        |=> clk_source == $past(q.oc[`RDCS_OC_CUR_LSB +: 3])) else $error("src lost");
    chk_noswitch_cfg: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && any_rst && !clk_switch_en)
        |=> clk_source == $past(new_osc_config_field)) else $error("cfg src");
    chk_reset_release: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(system_reset_signal) |-> $past(rst_done)) else $error("early release");
    chk_monitor_after: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(monitor_active) && is_pll(clk_source) |-> mon_done) else $error("early mon");
    // freeze, brown-out flag keeping and wake source keeping
    chk_freeze_state: assert property (@(posedge clk) disable iff (!rst_n)
        !ce |=> $stable(q)) else $error("state moved while frozen");
    chk_bor_keeps_por: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && events.bor && !events.por && !rc_wr && reset_control_reg[`RDCS_RC_POR])
        |=> reset_control_reg[`RDCS_RC_POR]) else $error("por flag lost");
    chk_wake_keep_src: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && events.wake && !any_rst && !oc_wr && (clock_valid || osc_fail_trap))
        |=> clk_source == $past(clk_source)) else $error("wake moved source");
endmodule
